// file: hdl/iprg_top.sv
// Two interrupt priority registers behind an APB slave.
// Assumes MCLK_I at 100 MHz and an arbiter that reads PRIO_O.
//
// Our own choices: register access over APB and the register addresses.
module iprg_top (
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   output iprg_pkg::iprg_prio_type PRIO_O,
   output logic [5:0] SRC_ENABLED_O
);
   import iprg_pkg::*;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta_q;
   logic rst_n_q;

   // Two-stage release of the asynchronous reset
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic access;
   logic wr_en;
   logic hit_a;
   logic hit_b;
   logic [15:0] wdata16;
   logic [15:0] wmask;

   assign access = PSEL_I && PENABLE_I;
   // Writes land only on the answer edge
   assign wr_en = access && PWRITE_I && PREADY_O;
   assign hit_a = (PADDR_I == ADC_UART_TX_PRIORITY_OFFS);
   assign hit_b = (PADDR_I == CHANGE_CMP_I2C_PRIORITY_OFFS);
   assign wdata16 = PWDATA_I[15:0];
   // Byte lanes gate the low halfword
   assign wmask = {{8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};

   // ----------------------------------------
   // Priority registers
   // ----------------------------------------
   logic [15:0] reg_a_q;
   logic [15:0] reg_b_q;

   // First register: ADC and UART transmitter fields
   always_ff @(posedge MCLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         reg_a_q <= ADC_UART_TX_RESET;
      end else if (wr_en && hit_a) begin
         // Only implemented bits take writes
         reg_a_q <= (reg_a_q & ~(wmask & ADC_UART_TX_MASK))
                    | (wdata16 & wmask & ADC_UART_TX_MASK);
      end
   end

   // Second register: change, comparator and I2C fields
   always_ff @(posedge MCLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         reg_b_q <= CHANGE_CMP_I2C_RESET;
      end else if (wr_en && hit_b) begin
         reg_b_q <= (reg_b_q & ~(wmask & CHANGE_CMP_I2C_MASK))
                    | (wdata16 & wmask & CHANGE_CMP_I2C_MASK);
      end
   end

   // ----------------------------------------
   // Read path and response
   // ----------------------------------------
   // Registered answer, one wait state per transfer
   always_ff @(posedge MCLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O <= 32'h0000_0000;
      end else if (access && !PREADY_O) begin
         PREADY_O <= 1'b1;
         PSLVERR_O <= !(hit_a || hit_b);
         if (!PWRITE_I && hit_a) begin
            PRDATA_O <= {16'h0000, reg_a_q & ADC_UART_TX_MASK};
         end else if (!PWRITE_I && hit_b) begin
            PRDATA_O <= {16'h0000, reg_b_q & CHANGE_CMP_I2C_MASK};
         end else begin
            PRDATA_O <= 32'h0000_0000;
         end
      end else begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
      end
   end

   // ----------------------------------------
   // Arbiter outputs
   // ----------------------------------------
   logic [5:0] enabled;

   // Nonzero code means source may request at that level
   always_comb begin
      enabled[5] = (reg_a_q[ADC_LSB +: PRIO_W] != PRIO_DISABLED);
      enabled[4] = (reg_a_q[UART_TX_LSB +: PRIO_W] != PRIO_DISABLED);
      enabled[3] = (reg_b_q[PIN_CHANGE_LSB +: PRIO_W] != PRIO_DISABLED);
      enabled[2] = (reg_b_q[COMPARATOR_LSB +: PRIO_W] != PRIO_DISABLED);
      enabled[1] = (reg_b_q[I2C_MASTER_LSB +: PRIO_W] != PRIO_DISABLED);
      enabled[0] = (reg_b_q[I2C_SLAVE_LSB +: PRIO_W] != PRIO_DISABLED);
   end

   // Field code is the level itself, one flop stage
   always_ff @(posedge MCLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         PRIO_O <= {6{PRIO_RESET}};
         SRC_ENABLED_O <= SRC_ENABLED_RESET;
      end else begin
         PRIO_O.adc_prio <= reg_a_q[ADC_LSB +: PRIO_W];
         PRIO_O.uart_tx_prio <= reg_a_q[UART_TX_LSB +: PRIO_W];
         PRIO_O.pin_change_prio <= reg_b_q[PIN_CHANGE_LSB +: PRIO_W];
         PRIO_O.comparator_prio <= reg_b_q[COMPARATOR_LSB +: PRIO_W];
         PRIO_O.i2c_master_prio <= reg_b_q[I2C_MASTER_LSB +: PRIO_W];
         PRIO_O.i2c_slave_prio <= reg_b_q[I2C_SLAVE_LSB +: PRIO_W];
         SRC_ENABLED_O <= enabled;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_pin_change_write: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (wr_en && hit_b && PSTRB_I[1]) |=> ##1
      (PRIO_O.pin_change_prio == $past(PWDATA_I[14:12], 2)))
      else $error("pin change priority not written");
   a_comparator_write: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (wr_en && hit_b && PSTRB_I[1]) |=> ##1
      (PRIO_O.comparator_prio == $past(PWDATA_I[10:8], 2)))
      else $error("comparator priority not written");
   a_i2c_master_write: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (wr_en && hit_b && PSTRB_I[0]) |=> ##1
      (PRIO_O.i2c_master_prio == $past(PWDATA_I[6:4], 2)))
      else $error("i2c master priority not written");
   a_i2c_slave_write: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (wr_en && hit_b && PSTRB_I[0]) |=> ##1
      (PRIO_O.i2c_slave_prio == $past(PWDATA_I[2:0], 2)))
      else $error("i2c slave priority not written");
   a_uart_tx_write: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (wr_en && hit_a && PSTRB_I[0]) |=> ##1
      (PRIO_O.uart_tx_prio == $past(PWDATA_I[2:0], 2)))
      else $error("uart transmit priority not written");
   a_adc_write: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (wr_en && hit_a && PSTRB_I[0]) |=> ##1
      (PRIO_O.adc_prio == $past(PWDATA_I[6:4], 2)))
      else $error("adc priority not written");
   a_highest_level: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (PRIO_O.pin_change_prio == PRIO_HIGHEST) |-> SRC_ENABLED_O[3])
      else $error("highest level not enabled");
   a_direct_level: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      ##1 (PRIO_O.comparator_prio == $past(reg_b_q[10:8])))
      else $error("comparator level not direct");
   a_disabled_code: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (PRIO_O.i2c_slave_prio == PRIO_DISABLED) |-> !SRC_ENABLED_O[0])
      else $error("disabled source still enabled");
   a_unimpl_zero: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      PREADY_O |-> ((PRDATA_O[31:15] == 17'h0_0000) && !PRDATA_O[11] && !PRDATA_O[7]
      && !PRDATA_O[3]))
      else $error("unimplemented bit reads one");
   a_reset_value: assert property (@(posedge MCLK_I)
      $rose(rst_n_q) |-> (PRIO_O == {6{PRIO_RESET}}))
      else $error("field reset value wrong");
   a_arbiter_follow: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      ##1 (PRIO_O.adc_prio == $past(reg_a_q[6:4])))
      else $error("arbiter copy lags");

   // ----------------------------------------
   // Bus answer checks
   // ----------------------------------------
   // One wait state, then a single answer cycle
   a_wait_state: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (access && !PREADY_O) |=> PREADY_O)
      else $error("answer not after one wait state");
   a_ready_pulse: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      PREADY_O |=> !PREADY_O)
      else $error("answer held too long");
   // Error flag rides on the answer cycle only
   a_error_answer: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      PSLVERR_O |-> PREADY_O)
      else $error("error flag without answer");
   a_mapped_no_error: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (access && !PREADY_O && (hit_a || hit_b)) |=> !PSLVERR_O)
      else $error("mapped access flagged as error");
   // Unmapped addresses are refused, read zero, write nothing
   a_unmapped_error: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (access && !PREADY_O && !hit_a && !hit_b)
      |=> (PSLVERR_O && (PRDATA_O == 32'h0000_0000)))
      else $error("unmapped access not refused");
   a_unmapped_nowrite: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (wr_en && !hit_a && !hit_b) |=> ($stable(reg_a_q) && $stable(reg_b_q)))
      else $error("unmapped write changed a register");

   // ----------------------------------------
   // Read path checks
   // ----------------------------------------
   // Each field reads back at its own bit position
   a_pin_change_read: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (access && !PREADY_O && !PWRITE_I && hit_b)
      |=> (PRDATA_O[14:12] == $past(reg_b_q[PIN_CHANGE_LSB +: PRIO_W])))
      else $error("pin change priority reads back wrong");
   a_comparator_read: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (access && !PREADY_O && !PWRITE_I && hit_b)
      |=> (PRDATA_O[10:8] == $past(reg_b_q[COMPARATOR_LSB +: PRIO_W])))
      else $error("comparator priority reads back wrong");
   a_i2c_master_read: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (access && !PREADY_O && !PWRITE_I && hit_b)
      |=> (PRDATA_O[6:4] == $past(reg_b_q[I2C_MASTER_LSB +: PRIO_W])))
      else $error("i2c master priority reads back wrong");
   a_i2c_slave_read: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (access && !PREADY_O && !PWRITE_I && hit_b)
      |=> (PRDATA_O[2:0] == $past(reg_b_q[I2C_SLAVE_LSB +: PRIO_W])))
      else $error("i2c slave priority reads back wrong");
   a_uart_tx_read: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (access && !PREADY_O && !PWRITE_I && hit_a)
      |=> (PRDATA_O[2:0] == $past(reg_a_q[UART_TX_LSB +: PRIO_W])))
      else $error("uart transmit priority reads back wrong");
   a_adc_read: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (access && !PREADY_O && !PWRITE_I && hit_a)
      |=> (PRDATA_O[6:4] == $past(reg_a_q[ADC_LSB +: PRIO_W])))
      else $error("adc priority reads back wrong");

   // ----------------------------------------
   // Register content checks
   // ----------------------------------------
   // Unimplemented positions never hold a one
   a_unimpl_first: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      ((reg_a_q & ~ADC_UART_TX_MASK) == 16'h0000))
      else $error("unimplemented bit set in first register");
   a_unimpl_second: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      ((reg_b_q & ~CHANGE_CMP_I2C_MASK) == 16'h0000))
      else $error("unimplemented bit set in second register");
   // Fields change only through a write to their register
   a_first_hold: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      !(wr_en && hit_a) |=> $stable(reg_a_q))
      else $error("first register changed without a write");
   a_second_hold: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      !(wr_en && hit_b) |=> $stable(reg_b_q))
      else $error("second register changed without a write");

   // ----------------------------------------
   // Reset checks
   // ----------------------------------------
   // Registers and outputs leave reset at their reset levels
   a_reset_regs: assert property (@(posedge MCLK_I)
      $rose(rst_n_q) |-> ((reg_a_q == ADC_UART_TX_RESET)
      && (reg_b_q == CHANGE_CMP_I2C_RESET)))
      else $error("register reset value wrong");
   a_reset_enables: assert property (@(posedge MCLK_I)
      $rose(rst_n_q) |-> (SRC_ENABLED_O == SRC_ENABLED_RESET))
      else $error("enable outputs reset value wrong");
   a_reset_bus: assert property (@(posedge MCLK_I)
      $rose(rst_n_q) |-> (!PREADY_O && !PSLVERR_O))
      else $error("bus answer active after reset");

   // ----------------------------------------
   // Arbiter checks
   // ----------------------------------------
   // Every level follows its field one clock later
   a_all_follow: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      ##1 (PRIO_O == $past({reg_a_q[6:4], reg_a_q[2:0], reg_b_q[14:12], reg_b_q[10:8],
      reg_b_q[6:4], reg_b_q[2:0]})))
      else $error("arbiter levels lag the registers");
   // Code zero masks the source, any other code enables it
   a_adc_disabled: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (reg_a_q[ADC_LSB +: PRIO_W] == PRIO_DISABLED) |=> !SRC_ENABLED_O[5])
      else $error("disabled adc source still enabled");
   a_uart_enabled: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (reg_a_q[UART_TX_LSB +: PRIO_W] != PRIO_DISABLED) |=> SRC_ENABLED_O[4])
      else $error("uart transmit source not enabled");
   // Code seven reaches the arbiter as the top level
   a_highest_passes: assert property (@(posedge MCLK_I) disable iff (!rst_n_q)
      (reg_b_q[COMPARATOR_LSB +: PRIO_W] == PRIO_HIGHEST)
      |=> ((PRIO_O.comparator_prio == PRIO_HIGHEST) && SRC_ENABLED_O[2]))
      else $error("highest comparator level lost");

endmodule // iprg_top

// file: hdl/iprg_pkg.sv
// Package for the interrupt priority register pair.
// Assumes a 32-bit APB slave, one aligned word per register.
package iprg_pkg;

   // ----------------------------------------
   // Register map and field layout
   // ----------------------------------------
   localparam logic [11:0] ADC_UART_TX_PRIORITY_OFFS = 12'h000;
   localparam logic [11:0] CHANGE_CMP_I2C_PRIORITY_OFFS = 12'h004;
   localparam int PRIO_W = 3;
   localparam int ADC_LSB = 4;
   localparam int UART_TX_LSB = 0;
   localparam int PIN_CHANGE_LSB = 12;
   localparam int COMPARATOR_LSB = 8;
   localparam int I2C_MASTER_LSB = 4;
   localparam int I2C_SLAVE_LSB = 0;
   localparam logic [15:0] ADC_UART_TX_MASK = 16'h0077;
   localparam logic [15:0] CHANGE_CMP_I2C_MASK = 16'h7777;

   // ----------------------------------------
   // Reset value and codes
   // ----------------------------------------
   localparam logic [2:0] PRIO_RESET = 3'h4;
   localparam logic [2:0] PRIO_DISABLED = 3'h0;
   localparam logic [2:0] PRIO_HIGHEST = 3'h7;
   localparam logic [15:0] ADC_UART_TX_RESET = 16'h0044;
   localparam logic [15:0] CHANGE_CMP_I2C_RESET = 16'h4444;
   localparam logic [5:0] SRC_ENABLED_RESET = 6'h3f;

   // Priority levels handed to the arbiter
   typedef struct packed {
      logic [2:0] adc_prio;
      logic [2:0] uart_tx_prio;
      logic [2:0] pin_change_prio;
      logic [2:0] comparator_prio;
      logic [2:0] i2c_master_prio;
      logic [2:0] i2c_slave_prio;
   } iprg_prio_type;

endpackage : iprg_pkg

// file: verif/test_iprg_top.sv
// Self-checking bench for the interrupt priority register pair.
// Assumes the APB slave answers every access within 20 clocks.
module test_iprg_top;
   timeunit 1ns;
   timeprecision 100ps;
   import iprg_pkg::*;
   logic MCLK_I = 1'b0, RST_N_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
   logic [11:0] PADDR_I = 12'h000;
   logic [31:0] PWDATA_I = 32'h0000_0000;
   logic [3:0] PSTRB_I = 4'hf;
   logic [31:0] PRDATA_O, rd;
   logic PREADY_O, PSLVERR_O, er;
   iprg_prio_type PRIO_O;
   logic [5:0] SRC_ENABLED_O;
   logic [15:0] r0, r1;
   int fails = 0, num_checks = 0;

   iprg_top iprg_top_inst (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
      .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
      .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
      .PRIO_O(PRIO_O), .SRC_ENABLED_O(SRC_ENABLED_O));

   // 100 MHz clock
   always #5 MCLK_I = ~MCLK_I;

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n = 0;
      @(posedge MCLK_I);
      PSEL_I <= 1'b1;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= d;
      PSTRB_I <= s;
      @(posedge MCLK_I);
      PENABLE_I <= 1'b1;
      do begin
         @(posedge MCLK_I);
         n++;
      end while (PREADY_O !== 1'b1 && n < 20);
      if (PREADY_O !== 1'b1) begin
         fails++;
         print_verdict();
      end else begin
         rd = PRDATA_O;
         er = PSLVERR_O;
         PSEL_I <= 1'b0;
         PENABLE_I <= 1'b0;
         check("slverr", 32'(er), 32'(a != 12'h000 && a != 12'h004));
      end
   endtask

   // Write and track the expected register contents with strobes
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [15:0] m;
      m = {{8{s[1]}}, {8{s[0]}}};
      apb(1'b1, a, d, s);
      if (a == 12'h000) r0 = (r0 & ~m) | (d[15:0] & m & 16'h0077);
      if (a == 12'h004) r1 = (r1 & ~m) | (d[15:0] & m & 16'h7777);
   endtask

   // Read back both registers and compare the arbiter outputs
   task automatic check_all();
      iprg_prio_type e;
      logic [5:0] en;
      apb(1'b0, ADC_UART_TX_PRIORITY_OFFS, 32'h0000_0000, 4'h0);
      check("first reg", rd, {16'h0000, r0});
      apb(1'b0, CHANGE_CMP_I2C_PRIORITY_OFFS, 32'h0000_0000, 4'h0);
      check("second reg", rd, {16'h0000, r1});
      e = {r0[6:4], r0[2:0], r1[14:12], r1[10:8], r1[6:4], r1[2:0]};
      for (int i = 0; i < 6; i++) en[i] = (e[3*i+:3] != 3'h0);
      check("prio", 32'(PRIO_O), 32'(e));
      check("enabled", 32'(SRC_ENABLED_O), 32'(en));
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      r0 = 16'h0044;
      r1 = 16'h4444;
      check_all();
   endtask

   // Every code in every field, pad bits written high
   task automatic t_codes();
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         wr(12'h000, {16'hffff, 1'b1, c, 1'b1, ~c, 1'b1, c, 1'b1, ~c}, 4'hf);
         wr(12'h004, {16'hffff, 1'b1, ~c, 1'b1, c, 1'b1, ~c, 1'b1, c}, 4'hf);
         check_all();
      end
   endtask

   // Single byte lanes, then unmapped write and read
   task automatic t_strobe_unmapped();
      wr(12'h004, 32'h0000_2615, 4'h1);
      wr(12'h004, 32'h0000_5a5a, 4'h2);
      wr(12'h000, 32'h0000_7777, 4'h2);
      wr(12'h008, 32'hffff_ffff, 4'hf);
      apb(1'b0, 12'h008, 32'h0000_0000, 4'h0);
      check("unmapped read", rd, 32'h0000_0000);
      check_all();
   endtask

   // Reset in mid-run restores every field
   task automatic t_reset_again();
      @(posedge MCLK_I);
      RST_N_I <= 1'b0;
      repeat (2) @(posedge MCLK_I);
      RST_N_I <= 1'b1;
      repeat (3) @(posedge MCLK_I);
      t_reset();
   endtask

   initial begin
      repeat (4) @(posedge MCLK_I);
      RST_N_I <= 1'b1;
      repeat (3) @(posedge MCLK_I);
      t_reset();
      t_codes();
      t_strobe_unmapped();
      t_reset_again();
      print_verdict();
   end
endmodule // test_iprg_top
